// ### gpdr_map.vh
// Purpose: register offsets, reset values and field positions for the pin pull-up and data block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef GPDR_MAP_VH
`define GPDR_MAP_VH

`define GPDR_OFF_PB_PULLUP_OFF  12'h000
`define GPDR_OFF_PC_PULLUP_OFF  12'h004
`define GPDR_OFF_PA_PIN_DATA    12'h008
`define GPDR_OFF_PA_DIRECTION   12'h00C
`define GPDR_OFF_PA_FUNC_LO     12'h010
`define GPDR_OFF_PA_FUNC_HI     12'h014
`define GPDR_OFF_STATUS         12'h018

`define GPDR_RST_PB_PULLUP_OFF  32'h00000000
`define GPDR_RST_PC_PULLUP_OFF  24'h000000
`define GPDR_RST_PA_LATCH       32'h00000000
`define GPDR_RST_PA_DIRECTION   32'h00000000
`define GPDR_RST_PA_FUNC        64'h0000000000000000

`define GPDR_PC_PINS            24
`define GPDR_FUNC_PLAIN_PIN     2'h0
`define GPDR_STATUS_UNLOCK_BIT  0

`endif

// ### gpdr_sync2.v
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage feeds only the second stage
module gpdr_sync2 #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // two stages, cleared by reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // gpdr_sync2

// ### gpdr_pin_drive.v
// Purpose: per-pin output driver for port A
// Assumes: function select is two bits per pin, plain pin function is code 0
// Notes:   latch reaches the pin only in plain-pin output mode
`include "gpdr_map.vh"

module gpdr_pin_drive #(
  parameter PINS = 32
) (
  // clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // configuration
  input  wire [PINS-1:0]   latch,
  input  wire [PINS-1:0]   direction,
  input  wire [2*PINS-1:0] func_sel,
  // pin side
  output reg  [PINS-1:0]   pin_out,
  output reg  [PINS-1:0]   pin_oe
);
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      wire drive_en = (func_sel[2*i+1:2*i] == `GPDR_FUNC_PLAIN_PIN) && direction[i];
      // registered drive so the outputs come from flops
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b0;
        end else begin
          pin_out[i] <= drive_en & latch[i];
          pin_oe[i]  <= drive_en;
        end
      end
    end
  endgenerate
endmodule // gpdr_pin_drive

// ### gpdr_top.v
// Purpose: apb register block for port pull-up disables and port A pin data
// Assumes: pins and unlock arrive asynchronously; qualification happens upstream
// Notes:   zero-wait apb slave, pslverr on unmapped address
//          pready answers in the cycle after setup and stands one cycle
//          pull-up, direction and function writes need the synced unlock
//          the data latch takes every write; reads show the synced pin
//          pins and unlock pass two flops, data reads lag the pin by three
//          unmapped writes change nothing; status reads show the synced unlock
`include "gpdr_map.vh"

module gpdr_top #(
  parameter PA_PINS = 32,
  parameter PB_PINS = 32,
  parameter PC_PINS = 24
) (
  // clock and reset
  input  wire               pclk,
  input  wire               presetn,
  // apb slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  // protection
  input  wire               protected_write_unlock,
  // port A pins, already qualified
  input  wire [PA_PINS-1:0] port_a_pin_in,
  output wire [PA_PINS-1:0] port_a_pin_out,
  output wire [PA_PINS-1:0] port_a_pin_oe,
  // pull-up controls, high turns the pull-up off
  output reg  [PB_PINS-1:0] port_b_pullup_off,
  output reg  [PC_PINS-1:0] port_c_pullup_off
);
  // register state
  reg  [PA_PINS-1:0]   pa_latch_q;
  reg  [PA_PINS-1:0]   pa_dir_q;
  reg  [2*PA_PINS-1:0] pa_func_q;
  reg  [PA_PINS-1:0]   pa_data_q;
  reg  [PA_PINS-1:0]   pa_data_d;
  reg                  unlock_meta_q;
  reg                  unlock_q;
  wire [PA_PINS-1:0]   pa_pin_sync;
  reg  [31:0]          rdata_d;
  reg                  hit_d;
  // address decode, one select per register
  reg                  sel_pb;
  reg                  sel_pc;
  reg                  sel_data;
  reg                  sel_dir;
  reg                  sel_flo;
  reg                  sel_fhi;
  reg                  sel_stat;
  // next values of the software-visible state
  reg  [PB_PINS-1:0]   pb_pullup_d;
  reg  [PC_PINS-1:0]   pc_pullup_d;
  reg  [PA_PINS-1:0]   pa_latch_d;
  reg  [PA_PINS-1:0]   pa_dir_d;
  reg  [2*PA_PINS-1:0] pa_func_d;
  // response next values
  reg                  pready_d;
  reg                  pslverr_d;
  reg  [31:0]          prdata_d;

  // pin levels cross into pclk before anything reads them
  gpdr_sync2 #(
    .WIDTH (PA_PINS)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (port_a_pin_in),
    .sync_out (pa_pin_sync)
  );

  // unlock level synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_meta_q <= 1'b0;
      unlock_q      <= 1'b0;
    end else begin
      unlock_meta_q <= protected_write_unlock;
      unlock_q      <= unlock_meta_q;
    end
  end

  // transfer phases; a write lands only at the edge that completes the access
  wire setup_ph   = psel & ~penable;
  wire acc_ph     = psel & penable & pready;
  wire wr_acc     = acc_ph & pwrite;
  wire rd_setup   = setup_ph & ~pwrite;
  wire prot_wr_ok = wr_acc & unlock_q;

  // address decode: at most one select is high, none for an unmapped word
  always @* begin
    sel_pb   = 1'b0;
    sel_pc   = 1'b0;
    sel_data = 1'b0;
    sel_dir  = 1'b0;
    sel_flo  = 1'b0;
    sel_fhi  = 1'b0;
    sel_stat = 1'b0;
    hit_d    = 1'b1;
    if (paddr == `GPDR_OFF_PB_PULLUP_OFF) begin
      sel_pb = 1'b1;
    end else if (paddr == `GPDR_OFF_PC_PULLUP_OFF) begin
      sel_pc = 1'b1;
    end else if (paddr == `GPDR_OFF_PA_PIN_DATA) begin
      sel_data = 1'b1;
    end else if (paddr == `GPDR_OFF_PA_DIRECTION) begin
      sel_dir = 1'b1;
    end else if (paddr == `GPDR_OFF_PA_FUNC_LO) begin
      sel_flo = 1'b1;
    end else if (paddr == `GPDR_OFF_PA_FUNC_HI) begin
      sel_fhi = 1'b1;
    end else if (paddr == `GPDR_OFF_STATUS) begin
      sel_stat = 1'b1;
    end else begin
      hit_d = 1'b0;
    end
  end

  // write strobes; the data latch takes any write, the rest need the unlock
  wire we_pb    = prot_wr_ok & sel_pb;
  wire we_pc    = prot_wr_ok & sel_pc;
  wire we_latch = wr_acc & sel_data;
  wire we_dir   = prot_wr_ok & sel_dir;
  wire we_flo   = prot_wr_ok & sel_flo;
  wire we_fhi   = prot_wr_ok & sel_fhi;

  // data readback tracks the qualified pin every cycle
  always @* begin
    pa_data_d = pa_pin_sync;
  end

  // readback register, three edges behind the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_q <= {PA_PINS{1'b0}};
    end else begin
      pa_data_q <= pa_data_d;
    end
  end

  // pull-up disable next values; a locked write leaves them as they are
  always @* begin
    pb_pullup_d = port_b_pullup_off;
    pc_pullup_d = port_c_pullup_off;
    if (we_pb) begin
      pb_pullup_d = pwdata[PB_PINS-1:0];
    end
    if (we_pc) begin
      pc_pullup_d = pwdata[PC_PINS-1:0];
    end
  end

  // port B pull-up disables, protected set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pullup_off <= `GPDR_RST_PB_PULLUP_OFF;
    end else begin
      port_b_pullup_off <= pb_pullup_d;
    end
  end

  // port C pull-up disables, reserved bits never stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_pullup_off <= `GPDR_RST_PC_PULLUP_OFF;
    end else begin
      port_c_pullup_off <= pc_pullup_d;
    end
  end

  // port A next values: latch on any data write, configuration when unlocked
  always @* begin
    pa_latch_d = pa_latch_q;
    pa_dir_d   = pa_dir_q;
    pa_func_d  = pa_func_q;
    if (we_latch) begin
      pa_latch_d = pwdata[PA_PINS-1:0];
    end
    if (we_dir) begin
      pa_dir_d = pwdata[PA_PINS-1:0];
    end
    if (we_flo) begin
      pa_func_d[31:0] = pwdata;
    end
    if (we_fhi) begin
      pa_func_d[63:32] = pwdata;
    end
  end

  // output latch, taken on any data write whatever the pin direction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_latch_q <= `GPDR_RST_PA_LATCH;
    end else begin
      pa_latch_q <= pa_latch_d;
    end
  end

  // direction bits, every pin an input after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_dir_q <= `GPDR_RST_PA_DIRECTION;
    end else begin
      pa_dir_q <= pa_dir_d;
    end
  end

  // function select, plain pin function after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_func_q <= `GPDR_RST_PA_FUNC;
    end else begin
      pa_func_q <= pa_func_d;
    end
  end

  // read mux: one word per mapped register, zero otherwise
  always @* begin
    rdata_d = 32'h00000000;
    if (sel_pb) begin
      rdata_d[PB_PINS-1:0] = port_b_pullup_off;
    end else if (sel_pc) begin
      rdata_d[PC_PINS-1:0] = port_c_pullup_off;
    end else if (sel_data) begin
      rdata_d[PA_PINS-1:0] = pa_data_q;
    end else if (sel_dir) begin
      rdata_d[PA_PINS-1:0] = pa_dir_q;
    end else if (sel_flo) begin
      rdata_d = pa_func_q[31:0];
    end else if (sel_fhi) begin
      rdata_d = pa_func_q[63:32];
    end else if (sel_stat) begin
      rdata_d[`GPDR_STATUS_UNLOCK_BIT] = unlock_q;
    end
  end

  // response next values: answer in the cycle after setup, no wait states
  always @* begin
    pready_d  = setup_ph;
    pslverr_d = setup_ph & ~hit_d;
    prdata_d  = 32'h00000000;
    if (rd_setup) begin
      prdata_d = rdata_d;
    end
  end

  // one wait-free access: pready rises in the access phase only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // read data register, zero outside a read answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_d;
    end
  end

  // port A output drivers
  gpdr_pin_drive #(
    .PINS (PA_PINS)
  ) u_drive (
    .pclk      (pclk),
    .presetn   (presetn),
    .latch     (pa_latch_q),
    .direction (pa_dir_q),
    .func_sel  (pa_func_q),
    .pin_out   (port_a_pin_out),
    .pin_oe    (port_a_pin_oe)
  );
endmodule // gpdr_top

// ### gpdr_sva.sv
// Purpose: port checks for the pull-up and pin data block
// Assumes: unlock is held low through reset
// Notes:   pin read check waits for pins stable five edges
module gpdr_sva #(
  parameter PA_PINS = 32,
  parameter PB_PINS = 32,
  parameter PC_PINS = 24
) (
  // clock, reset and apb
  input wire logic               pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata, prdata,
  // protection and pins
  input wire logic               protected_write_unlock,
  input wire logic [PA_PINS-1:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe,
  input wire logic [PB_PINS-1:0] port_b_pullup_off,
  input wire logic [PC_PINS-1:0] port_c_pullup_off
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [PA_PINS-1:0] pin_d_q;
  logic [2:0]         stab_q;
  logic               unl_h1_q;
  logic               unl_h2_q;
  wire                acc  = psel & penable & pready;
  wire                unl3 = protected_write_unlock & unl_h1_q & unl_h2_q;
  wire                lck3 = !(protected_write_unlock | unl_h1_q | unl_h2_q);
  // counts edges over which the pins stayed put, and keeps two edges of unlock history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_q  <= {PA_PINS{1'b0}};
      stab_q   <= 3'h0;
      unl_h1_q <= 1'b0;
      unl_h2_q <= 1'b0;
    end else begin
      unl_h1_q <= protected_write_unlock;
      unl_h2_q <= unl_h1_q;
      pin_d_q  <= port_a_pin_in;
      stab_q  <= (port_a_pin_in != pin_d_q) ? 3'h0 : ((stab_q == 3'h7) ? stab_q : stab_q + 3'h1);
    end
  end
  chk_rdy_once: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  chk_rdy_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  chk_b_lock: assert property (acc && pwrite && paddr == 12'h000 && lck3
    |=> $stable(port_b_pullup_off)) else $error("locked pull-up write took effect");
  chk_b_write: assert property (acc && pwrite && paddr == 12'h000 && unl3
    |=> port_b_pullup_off == $past(pwdata)) else $error("port b pull-up write lost");
  chk_c_write: assert property (acc && pwrite && paddr == 12'h004 && unl3
    |=> {8'h00, port_c_pullup_off} == ($past(pwdata) & 32'h00FFFFFF)) else $error("port c write lost");
  chk_c_rsvd: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata[31:24] == 8'h00)
    else $error("port c reserved bits set");
  chk_latch_drive: assert property (acc && pwrite && paddr == 12'h008
    |=> ##1 ((port_a_pin_out ^ $past(pwdata, 2)) & port_a_pin_oe) == 32'h0) else $error("pin not driven from latch");
  chk_rd_pin: assert property (acc && !pwrite && paddr == 12'h008 && stab_q >= 3'h5 |-> prdata == pin_d_q)
    else $error("data read differs from pin");
  chk_unmapped: assert property (acc && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // gpdr_sva
bind gpdr_top gpdr_sva #(.PA_PINS(PA_PINS), .PB_PINS(PB_PINS), .PC_PINS(PC_PINS)) u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .protected_write_unlock(protected_write_unlock),
  .port_a_pin_in(port_a_pin_in), .port_a_pin_out(port_a_pin_out), .port_a_pin_oe(port_a_pin_oe),
  .port_b_pullup_off(port_b_pullup_off), .port_c_pullup_off(port_c_pullup_off));

// ### gpdr_board.sv
// Purpose: board side of the port A pins
// Assumes: an undriven pin follows the board level
// Notes:   qualification is taken as already done
module gpdr_board (
  // pin side
  input  wire logic [31:0] pin_out, pin_oe, ext_lvl,
  output wire logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the driven level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpdr_board

// ### tb_top.sv
// Purpose: self-checking bench for the pull-up and pin data block
// Assumes: zero-wait apb slave, unlock and pins synced in two to three edges
// Notes:   model values are plain vectors kept by the bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
  logic        pclk, presetn, psel, penable, pwrite, protected_write_unlock, pready, pslverr, pe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ext, pin_in, pin_out, pin_oe, pbo, r, pb, pc, lat, dir, fhi, oe;
  logic [23:0] pco;
  int          num_errors = 0;
  int          cmp_count = 0;
  gpdr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .protected_write_unlock(protected_write_unlock),
    .port_a_pin_in(pin_in), .port_a_pin_out(pin_out), .port_a_pin_oe(pin_oe), .port_b_pullup_off(pbo),
    .port_c_pullup_off(pco));
  gpdr_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in));
  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one apb transfer, answer left in r and pe
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      stop_test;
    end else begin
      r = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, protected_write_unlock, paddr, pwdata} = '0;
    void'($urandom(22300));
    ext = $urandom;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CK({r, pbo, pco}, 88'h0)
    apb(1'b0, 12'h008, 32'h0);
    `CK({r, pin_oe}, {ext, 32'h0})
    apb(1'b1, 12'h000, $urandom);
    apb(1'b0, 12'h000, 32'h0);
    `CK(r, 32'h0)
    protected_write_unlock <= 1'b1;
    repeat (6) @(posedge pclk);
    for (int k = 0; k < 6; k++) begin
      {pb, pc, lat, dir, fhi} = {$urandom, $urandom, $urandom, $urandom, $urandom};
      ext <= $urandom;
      apb(1'b1, 12'h000, pb);
      apb(1'b1, 12'h004, pc);
      apb(1'b1, 12'h008, lat);
      apb(1'b1, 12'h00C, dir);
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h014, fhi);
      repeat (6) @(posedge pclk);
      oe = dir;
      for (int i = 0; i < 16; i++)
        oe[16+i] = dir[16+i] & (fhi[2*i+:2] == 2'h0);
      `CK({pbo, pco}, {pb, pc[23:0]})
      `CK({pin_oe, pin_out}, {oe, lat & oe})
      apb(1'b0, 12'h004, 32'h0);
      `CK(r, pc & 32'h00FFFFFF)
      apb(1'b0, 12'h008, 32'h0);
      `CK(r, (oe & lat) | (~oe & ext))
    end
    apb(1'b0, 12'h01C, 32'h0);
    `CK({pe, r}, 33'h100000000)
    protected_write_unlock <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, 12'h000, ~pb);
    apb(1'b0, 12'h000, 32'h0);
    `CK(r, pb)
    stop_test;
  end
endmodule // tb_top
